// ---- hdl/prf_defs.vh ----
// register map, field positions and reset values of the receive ptp filter/capture block
`ifndef PRF_DEFS_VH
`define PRF_DEFS_VH

// ----------------------------------------------------------------
// byte addresses
// ----------------------------------------------------------------
`define PRF_OFF_BANK_SEL      12'h100
`define PRF_OFF_PTP_CFG       12'h104
`define PRF_OFF_CAPTURE_COUNT 12'h108
`define PRF_OFF_CF_MOD        12'h164
`define PRF_OFF_FILTER_CFG    12'h168
`define PRF_OFF_CAP_SEC       12'h16c
`define PRF_OFF_CAP_NS        12'h170
`define PRF_OFF_CAP_HDR       12'h174
`define PRF_OFF_FILTERED_PACKET_TALLY  12'h18c

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define PRF_BANK_LSB          0
`define PRF_BANK_MSB          2
`define PRF_PORT_LSB          4
`define PRF_PORT_MSB          5
`define PRF_BANK_PORT         3'h1
`define PRF_VER_LSB           16
`define PRF_VER_MSB           19
`define PRF_DOM_LSB           0
`define PRF_DOM_MSB           7
`define PRF_FLT_VER_BIT       16
`define PRF_FLT_DOM_BIT       17
`define PRF_FLT_ALT_BIT       18
`define PRF_HDR_CRC_LSB       20
`define PRF_HDR_TYPE_LSB      16
`define PRF_FIFO_DEPTH        3'h4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PRF_RST_CF_MOD        16'h000f
`define PRF_RST_FILTER        19'h00000
`define PRF_RST_VERSION       4'h2
`define PRF_RST_DOMAIN        8'h00
`define PRF_RST_BANK          6'h00
`define PRF_RESP_OKAY         2'h0
`define PRF_RESP_SLVERR       2'h2

`endif

// ---- hdl/prf_capture_mem.v ----
// four-entry capture store with registered, write-through read port
`timescale 1ns/1ps
module prf_capture_mem (
    // clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // write side
    input  wire        we,
    input  wire [1:0]  waddr,
    input  wire [93:0] wdata,
    // read side
    input  wire [1:0]  raddr,
    output reg  [93:0] rdata
);
    reg [93:0] mem [0:3];
    integer    i;

    // cleared so the capture registers read zero before the first capture
    always @(posedge aclk) begin
        if (!aresetn) begin
            for (i = 0; i < 4; i = i + 1) begin
                mem[i] <= 94'h0;
            end
        end else if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // bypass so a fresh entry is visible on the same edge that writes it
    always @(posedge aclk) begin
        if (!aresetn) begin
            rdata <= 94'h0;
        end else if (we && (waddr == raddr)) begin
            rdata <= wdata;
        end else begin
            rdata <= mem[raddr];
        end
    end
endmodule

// ---- hdl/prf_filter.v ----
// ingress message filter and correction-modify decision, one cycle of latency
`timescale 1ns/1ps
module prf_filter (
    // clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // parsed message
    input  wire        msg_valid,
    input  wire [3:0]  captured_message_kind,
    input  wire [3:0]  msg_version,
    input  wire [7:0]  msg_domain,
    input  wire        msg_alt_master,
    // configuration
    input  wire [15:0] correction_modify_type_mask,
    input  wire [15:0] message_type_filter_mask,
    input  wire        version_filter_on,
    input  wire        domain_filter_on,
    input  wire        alternate_master_filter_on,
    input  wire [3:0]  expected_protocol_version,
    input  wire [7:0]  domain_value,
    // decision
    output reg         drop,
    output reg         pass,
    output reg         cf_modify
);
    wire type_hit = message_type_filter_mask[captured_message_kind];
    // zero version accepts every version
    wire ver_hit  = version_filter_on && (expected_protocol_version != 4'h0) &&
                    (msg_version != expected_protocol_version);
    wire dom_hit  = domain_filter_on && (msg_domain != domain_value);
    wire alt_hit  = alternate_master_filter_on && msg_alt_master;
    wire reject   = type_hit | ver_hit | dom_hit | alt_hit;

    always @(posedge aclk) begin
        if (!aresetn) begin
            drop      <= 1'b0;
            pass      <= 1'b0;
            cf_modify <= 1'b0;
        end else begin
            drop      <= msg_valid & reject;
            pass      <= msg_valid & ~reject;
            cf_modify <= msg_valid & ~reject & correction_modify_type_mask[captured_message_kind];
        end
    end
endmodule

// ---- hdl/prf_rx_ptp.v ----
// receive ptp filter, correction enable and timestamp capture of one switch port
`timescale 1ns/1ps
`include "prf_defs.vh"
module prf_rx_ptp #(
    parameter [1:0] PORT_ID = 2'h0
) (
    // clock and reset
    input  wire        aclk,
    input  wire        aresetn,
    // axi4-lite write address and data
    input  wire [11:0] awaddr,
    input  wire        awvalid,
    output reg         awready,
    input  wire [31:0] wdata,
    input  wire [3:0]  wstrb,
    input  wire        wvalid,
    output reg         wready,
    // axi4-lite write response
    output reg  [1:0]  bresp,
    output reg         bvalid,
    input  wire        bready,
    // axi4-lite read
    input  wire [11:0] araddr,
    input  wire        arvalid,
    output reg         arready,
    output reg  [31:0] rdata,
    output reg  [1:0]  rresp,
    output reg         rvalid,
    input  wire        rready,
    // parsed ingress message from the receive mac
    input  wire        msg_valid,
    input  wire [3:0]  captured_message_kind,
    input  wire [3:0]  msg_version,
    input  wire [7:0]  msg_domain,
    input  wire        msg_alt_master,
    input  wire        msg_capture_req,
    input  wire [15:0] msg_sequence,
    input  wire [11:0] msg_source_crc,
    input  wire [31:0] ingress_seconds,
    input  wire [29:0] ingress_nanoseconds,
    // capture release from the count logic
    input  wire        capture_pop,
    // decisions back to the mac
    output wire        msg_drop,
    output wire        mac_error,
    output wire        cf_modify,
    output reg  [2:0]  rx_capture_count
);
    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    reg  [15:0] correction_modify_type_mask;
    reg  [18:0] filter_cfg;
    reg  [3:0]  expected_protocol_version;
    reg  [7:0]  domain_value;
    reg  [5:0]  bank_port_select;
    reg  [31:0] filtered_packet_tally;
    reg  [1:0]  wr_ptr;
    reg  [1:0]  rd_ptr;
    wire [93:0] head;
    wire        flt_drop;
    wire        flt_pass;

    // payload held for the one cycle the filter takes
    reg         cap_req_q;
    reg  [93:0] cap_word_q;

    wire port_sel = (bank_port_select[`PRF_BANK_MSB:`PRF_BANK_LSB] == `PRF_BANK_PORT) &&
                    (bank_port_select[`PRF_PORT_MSB:`PRF_PORT_LSB] == PORT_ID);

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    function known;
        input [11:0] a;
        input        ps;
        begin
            case (a)
                `PRF_OFF_BANK_SEL,
                `PRF_OFF_PTP_CFG,
                `PRF_OFF_CAPTURE_COUNT: known = 1'b1;
                `PRF_OFF_CF_MOD,
                `PRF_OFF_FILTER_CFG,
                `PRF_OFF_CAP_SEC,
                `PRF_OFF_CAP_NS,
                `PRF_OFF_CAP_HDR,
                `PRF_OFF_FILTERED_PACKET_TALLY:  known = ps;
                default:                known = 1'b0;
            endcase
        end
    endfunction

    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0]  s;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (s[i]) begin
                    merge[i*8 +: 8] = nw[i*8 +: 8];
                end
            end
        end
    endfunction

    // ----------------------------------------------------------------
    // write channel
    // ----------------------------------------------------------------
    reg         aw_full;
    reg         w_full;
    reg  [11:0] awaddr_q;
    reg  [31:0] wdata_q;
    reg  [3:0]  wstrb_q;

    wire aw_take = awvalid & awready;
    wire w_take  = wvalid & wready;
    wire do_write = aw_full & w_full & ~bvalid;
    wire wr_hit  = known(awaddr_q, port_sel);
    wire next_bvalid  = do_write | (bvalid & ~bready);
    wire next_aw_full = (aw_full | aw_take) & ~do_write;
    wire next_w_full  = (w_full | w_take) & ~do_write;

    always @(posedge aclk) begin
        if (!aresetn) begin
            awready  <= 1'b0;
            wready   <= 1'b0;
            bvalid   <= 1'b0;
            bresp    <= `PRF_RESP_OKAY;
            aw_full  <= 1'b0;
            w_full   <= 1'b0;
            awaddr_q <= 12'h0;
            wdata_q  <= 32'h0;
            wstrb_q  <= 4'h0;
        end else begin
            if (aw_take) begin
                awaddr_q <= awaddr;
            end
            if (w_take) begin
                wdata_q <= wdata;
                wstrb_q <= wstrb;
            end
            aw_full <= next_aw_full;
            w_full  <= next_w_full;
            awready <= ~next_aw_full & ~next_bvalid;
            wready  <= ~next_w_full & ~next_bvalid;
            bvalid  <= next_bvalid;
            if (do_write) begin
                bresp <= wr_hit ? `PRF_RESP_OKAY : `PRF_RESP_SLVERR;
            end
        end
    end

    wire [31:0] cfg_word = {12'h0, expected_protocol_version, 8'h0, domain_value};
    wire [31:0] flt_word = {13'h0, filter_cfg};
    wire [31:0] bank_merged = merge({26'h0, bank_port_select}, wdata_q, wstrb_q);
    wire [31:0] cfg_merged  = merge(cfg_word, wdata_q, wstrb_q);
    wire [31:0] cf_merged   = merge({16'h0, correction_modify_type_mask}, wdata_q, wstrb_q);
    wire [31:0] flt_merged  = merge(flt_word, wdata_q, wstrb_q);
    wire        wr_tally = do_write & wr_hit & (awaddr_q == `PRF_OFF_FILTERED_PACKET_TALLY);
    wire [31:0] tally_base = wr_tally ? merge(filtered_packet_tally, wdata_q, wstrb_q)
                                      : filtered_packet_tally;

    always @(posedge aclk) begin
        if (!aresetn) begin
            correction_modify_type_mask <= `PRF_RST_CF_MOD;
            filter_cfg                  <= `PRF_RST_FILTER;
            expected_protocol_version   <= `PRF_RST_VERSION;
            domain_value                <= `PRF_RST_DOMAIN;
            bank_port_select            <= `PRF_RST_BANK;
        end else if (do_write && wr_hit) begin
            case (awaddr_q)
                `PRF_OFF_BANK_SEL: begin
                    bank_port_select <= bank_merged[5:0];
                end
                `PRF_OFF_PTP_CFG: begin
                    {expected_protocol_version, domain_value} <=
                        {cfg_merged[`PRF_VER_MSB:`PRF_VER_LSB], cfg_merged[`PRF_DOM_MSB:`PRF_DOM_LSB]};
                end
                `PRF_OFF_CF_MOD: begin
                    correction_modify_type_mask <= cf_merged[15:0];
                end
                `PRF_OFF_FILTER_CFG: begin
                    filter_cfg <= flt_merged[18:0];
                end
                default: begin
                end
            endcase
        end
    end

    // a drop in the same cycle as a software write still counts
    always @(posedge aclk) begin
        if (!aresetn) begin
            filtered_packet_tally <= 32'h0;
        end else if (flt_drop && (tally_base != 32'hffffffff)) begin
            filtered_packet_tally <= tally_base + 32'h1;
        end else begin
            filtered_packet_tally <= tally_base;
        end
    end

    // ----------------------------------------------------------------
    // filter
    // ----------------------------------------------------------------
    prf_filter u_filter (
        .aclk                        (aclk),
        .aresetn                     (aresetn),
        .msg_valid                   (msg_valid),
        .captured_message_kind                    (captured_message_kind),
        .msg_version                 (msg_version),
        .msg_domain                  (msg_domain),
        .msg_alt_master              (msg_alt_master),
        .correction_modify_type_mask (correction_modify_type_mask),
        .message_type_filter_mask    (filter_cfg[15:0]),
        .version_filter_on           (filter_cfg[`PRF_FLT_VER_BIT]),
        .domain_filter_on            (filter_cfg[`PRF_FLT_DOM_BIT]),
        .alternate_master_filter_on  (filter_cfg[`PRF_FLT_ALT_BIT]),
        .expected_protocol_version   (expected_protocol_version),
        .domain_value                (domain_value),
        .drop                        (flt_drop),
        .pass                        (flt_pass),
        .cf_modify                   (cf_modify)
    );

    assign msg_drop  = flt_drop;
    assign mac_error = flt_drop;

    // ----------------------------------------------------------------
    // capture buffer
    // ----------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            cap_req_q  <= 1'b0;
            cap_word_q <= 94'h0;
        end else begin
            cap_req_q <= msg_valid & msg_capture_req;
            if (msg_valid) begin
                cap_word_q <= {ingress_seconds, ingress_nanoseconds, msg_source_crc,
                               captured_message_kind, msg_sequence};
            end
        end
    end

    wire not_empty = (rx_capture_count != 3'h0);
    wire do_pop    = capture_pop & not_empty;
    // a capture arriving with all four slots held is lost unless a pop frees one in the same cycle
    wire do_push   = flt_pass & cap_req_q &
                     ((rx_capture_count != `PRF_FIFO_DEPTH) | do_pop);
    wire [1:0] next_rd_ptr = do_pop ? rd_ptr + 2'h1 : rd_ptr;

    always @(posedge aclk) begin
        if (!aresetn) begin
            wr_ptr           <= 2'h0;
            rd_ptr           <= 2'h0;
            rx_capture_count <= 3'h0;
        end else begin
            if (do_push) begin
                wr_ptr <= wr_ptr + 2'h1;
            end
            rd_ptr <= next_rd_ptr;
            case ({do_push, do_pop})
                2'b10:   rx_capture_count <= rx_capture_count + 3'h1;
                2'b01:   rx_capture_count <= rx_capture_count - 3'h1;
                default: rx_capture_count <= rx_capture_count;
            endcase
        end
    end

    // one word per entry keeps seconds, ns and header together
    prf_capture_mem u_mem (
        .aclk    (aclk),
        .aresetn (aresetn),
        .we      (do_push),
        .waddr   (wr_ptr),
        .wdata   (cap_word_q),
        .raddr   (next_rd_ptr),
        .rdata   (head)
    );

    // ----------------------------------------------------------------
    // read channel
    // ----------------------------------------------------------------
    reg [31:0] rd_mux;

    always @* begin
        rd_mux = 32'h0;
        case (araddr)
            `PRF_OFF_BANK_SEL:      rd_mux = {26'h0, bank_port_select};
            `PRF_OFF_PTP_CFG:       rd_mux = cfg_word;
            `PRF_OFF_CAPTURE_COUNT: rd_mux = {29'h0, rx_capture_count};
            `PRF_OFF_CF_MOD:        rd_mux = {16'h0, correction_modify_type_mask};
            `PRF_OFF_FILTER_CFG:    rd_mux = flt_word;
            `PRF_OFF_CAP_SEC:       rd_mux = head[93:62];
            `PRF_OFF_CAP_NS:        rd_mux = {2'h0, head[61:32]};
            `PRF_OFF_CAP_HDR:       rd_mux = head[31:0];
            `PRF_OFF_FILTERED_PACKET_TALLY:  rd_mux = filtered_packet_tally;
            default:                rd_mux = 32'h0;
        endcase
    end

    wire ar_take     = arvalid & arready;
    wire rd_hit      = known(araddr, port_sel);
    wire next_rvalid = ar_take | (rvalid & ~rready);

    always @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h0;
            rresp   <= `PRF_RESP_OKAY;
        end else begin
            arready <= ~next_rvalid;
            rvalid  <= next_rvalid;
            if (ar_take) begin
                rdata <= rd_hit ? rd_mux : 32'h0;
                rresp <= rd_hit ? `PRF_RESP_OKAY : `PRF_RESP_SLVERR;
            end
        end
    end
endmodule

// ---- verif/prf_rx_ptp_monitor.sv ----
// concurrent checks on the ports of the receive ptp filter/capture block
`timescale 1ns/1ps
module prf_rx_ptp_monitor (
    // clock and reset
    input wire       aclk,
    input wire       aresetn,
    // register bus handshakes
    input wire       awvalid,
    input wire       awready,
    input wire       wvalid,
    input wire       wready,
    input wire       bvalid,
    input wire       arvalid,
    input wire       arready,
    input wire       rvalid,
    // message path
    input wire       msg_valid,
    input wire       msg_capture_req,
    input wire       capture_pop,
    input wire       msg_drop,
    input wire       mac_error,
    input wire       cf_modify,
    input wire [2:0] rx_capture_count
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_drop_flags_error: assert property (mac_error == msg_drop)
        else $error("mac error differs from drop");
    a_drop_after_msg: assert property (msg_drop |-> $past(msg_valid))
        else $error("drop without a message");
    a_cf_on_passed: assert property (cf_modify |-> $past(msg_valid) && !msg_drop)
        else $error("correction modify on a dropped or absent message");
    a_count_in_range: assert property (rx_capture_count <= 3'h4)
        else $error("capture count above four");
    // guard on past reset: a one-edge reset may leave an old count in the history
    a_count_one_step: assert property ($past(aresetn) && rx_capture_count != $past(rx_capture_count)
        |-> rx_capture_count == $past(rx_capture_count) + 3'h1
         || rx_capture_count == $past(rx_capture_count) - 3'h1)
        else $error("capture count jumped");
    a_push_has_cause: assert property ($past(aresetn) && rx_capture_count > $past(rx_capture_count)
        |-> $past(msg_valid, 2) && $past(msg_capture_req, 2) && !$past(msg_drop))
        else $error("capture stored without a passed request");
    a_full_holds: assert property (rx_capture_count == 3'h4 && !capture_pop
        |=> rx_capture_count == 3'h4)
        else $error("full store changed without a pop");
    a_write_answered: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
        else $error("write response late");
    a_read_answered: assert property (arvalid && arready |=> rvalid)
        else $error("read data late");
endmodule

bind prf_rx_ptp prf_rx_ptp_monitor i_prf_rx_ptp_monitor (
    .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
    .wready(wready), .bvalid(bvalid), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
    .msg_valid(msg_valid), .msg_capture_req(msg_capture_req), .capture_pop(capture_pop),
    .msg_drop(msg_drop), .mac_error(mac_error), .cf_modify(cf_modify),
    .rx_capture_count(rx_capture_count)
);

// ---- verif/prf_rx_ptp_tb.sv ----
// self-checking bench of the receive ptp filter/capture block
`timescale 1ns/1ps
`include "prf_defs.vh"
module prf_rx_ptp_tb;
    reg         aclk = 1'b0;
    reg         aresetn = 1'b0;
    reg  [11:0] awaddr = 12'h000;
    reg         awvalid = 1'b0;
    reg  [31:0] wdata = 32'h0;
    reg         wvalid = 1'b0;
    reg         bready = 1'b0;
    reg  [11:0] araddr = 12'h000;
    reg         arvalid = 1'b0;
    reg         rready = 1'b0;
    reg         msg_valid = 1'b0;
    reg  [3:0]  captured_message_kind = 4'h0;
    reg  [3:0]  msg_version = 4'h0;
    reg  [7:0]  msg_domain = 8'h00;
    reg         msg_alt_master = 1'b0;
    reg         msg_capture_req = 1'b0;
    reg  [15:0] msg_sequence = 16'h0;
    reg  [11:0] msg_source_crc = 12'h0;
    reg  [31:0] ingress_seconds = 32'h0;
    reg  [29:0] ingress_nanoseconds = 30'h0;
    reg         capture_pop = 1'b0;
    wire        awready, wready, bvalid, arready, rvalid, msg_drop, mac_error, cf_modify;
    wire [1:0]  bresp, rresp;
    wire [31:0] rdata;
    wire [2:0]  rx_capture_count;
    integer     n_errors = 0;
    integer     samples_checked = 0;

    // port 2 so that a wrong port field is distinguishable from the reset value
    prf_rx_ptp #(.PORT_ID(2'h2)) i_prf_rx_ptp (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .msg_valid(msg_valid), .captured_message_kind(captured_message_kind), .msg_version(msg_version),
        .msg_domain(msg_domain), .msg_alt_master(msg_alt_master),
        .msg_capture_req(msg_capture_req), .msg_sequence(msg_sequence),
        .msg_source_crc(msg_source_crc), .ingress_seconds(ingress_seconds),
        .ingress_nanoseconds(ingress_nanoseconds), .capture_pop(capture_pop),
        .msg_drop(msg_drop), .mac_error(mac_error), .cf_modify(cf_modify),
        .rx_capture_count(rx_capture_count)
    );

    initial begin
        forever #2.5 aclk = ~aclk;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task tally_and_finish;
        begin
            $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
            if (n_errors == 0 && samples_checked > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask

    task chk(input string nm, input [31:0] e, input [31:0] g);
        begin
            samples_checked = samples_checked + 1;
            if (g !== e) begin
                $display("FAIL %s expected %h seen %h", nm, e, g);
                n_errors = n_errors + 1;
            end
        end
    endtask

    task give_up(input got);
        begin
            if (!got) begin
                $display("FAIL handshake expected answer seen none");
                n_errors = n_errors + 1;
                tally_and_finish;
            end
        end
    endtask

    task wr(input [11:0] a, input [31:0] d, input [1:0] er);
        integer k;
        reg     got;
        begin
            got = 1'b0;
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            for (k = 0; k < 50 && !got; k = k + 1) begin
                @(posedge aclk);
                if (bvalid) begin
                    got = 1'b1;
                    chk($sformatf("bresp %h", a), er, bresp);
                end
                if (awready) awvalid <= 1'b0;
                if (wready) wvalid <= 1'b0;
            end
            bready <= 1'b0;
            give_up(got);
            @(posedge aclk);
        end
    endtask

    task rd(input [11:0] a, input [31:0] e, input [1:0] er);
        integer k;
        reg     got;
        begin
            got = 1'b0;
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            for (k = 0; k < 50 && !got; k = k + 1) begin
                @(posedge aclk);
                if (rvalid) begin
                    got = 1'b1;
                    chk($sformatf("rdata %h", a), e, rdata);
                    chk($sformatf("rresp %h", a), er, rresp);
                end
                if (arready) arvalid <= 1'b0;
            end
            rready <= 1'b0;
            give_up(got);
            @(posedge aclk);
        end
    endtask

    task send(input [3:0] t, input [3:0] v, input [7:0] dm, input alt, input cap,
              input [3:0] i, input ed, input ec);
        begin
            captured_message_kind <= t;
            msg_version <= v;
            msg_domain <= dm;
            msg_alt_master <= alt;
            msg_capture_req <= cap;
            msg_sequence <= 16'h1000 + i;
            msg_source_crc <= 12'ha00 + i;
            ingress_seconds <= 32'h50000000 + i;
            ingress_nanoseconds <= 30'h3fffff00 + i;
            msg_valid <= 1'b1;
            @(posedge aclk);
            msg_valid <= 1'b0;
            #1;
            chk("msg_drop", ed, msg_drop);
            chk("mac_error", ed, mac_error);
            chk("cf_modify", ec, cf_modify);
            @(posedge aclk);
        end
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task t_reset_bank;
        begin
            rd(12'h164, 32'h0, `PRF_RESP_SLVERR);
            wr(12'h100, 32'h21, `PRF_RESP_OKAY);
            rd(12'h100, 32'h21, `PRF_RESP_OKAY);
            rd(12'h164, 32'h0000000f, `PRF_RESP_OKAY);
            rd(12'h168, 32'h0, `PRF_RESP_OKAY);
            rd(12'h16c, 32'h0, `PRF_RESP_OKAY);
            rd(12'h170, 32'h0, `PRF_RESP_OKAY);
            rd(12'h174, 32'h0, `PRF_RESP_OKAY);
            rd(12'h104, 32'h00020000, `PRF_RESP_OKAY);
            rd(12'h1f0, 32'h0, `PRF_RESP_SLVERR);
            wr(12'h100, 32'h11, `PRF_RESP_OKAY);
            rd(12'h164, 32'h0, `PRF_RESP_SLVERR);
            wr(12'h164, 32'h0, `PRF_RESP_SLVERR);
            wr(12'h100, 32'h21, `PRF_RESP_OKAY);
            rd(12'h164, 32'h0000000f, `PRF_RESP_OKAY);
        end
    endtask

    task t_type_masks;
        integer m;
        integer t;
        reg     dr;
        begin
            for (m = 0; m < 2; m = m + 1) begin
                // delay request/response dropped, as a peer-to-peer setup would ask
                wr(12'h168, (m == 1) ? 32'h6 : 32'h0, `PRF_RESP_OKAY);
                for (t = 0; t < 16; t = t + 1) begin
                    dr = (m == 1) && (t == 1 || t == 2);
                    send(t[3:0], 4'h2, 8'h00, 1'b0, 1'b0, 4'h0, dr, !dr && t < 4);
                end
            end
        end
    endtask

    task t_field_filters;
        begin
            wr(12'h104, 32'h00020005, `PRF_RESP_OKAY);
            wr(12'h168, 32'h00070000, `PRF_RESP_OKAY);
            send(4'h0, 4'h2, 8'h05, 1'b0, 1'b0, 4'h0, 1'b0, 1'b1);
            send(4'h0, 4'h3, 8'h05, 1'b0, 1'b0, 4'h0, 1'b1, 1'b0);
            send(4'h0, 4'h2, 8'h04, 1'b0, 1'b0, 4'h0, 1'b1, 1'b0);
            send(4'h0, 4'h2, 8'h05, 1'b1, 1'b0, 4'h0, 1'b1, 1'b0);
            wr(12'h104, 32'h00000005, `PRF_RESP_OKAY);
            send(4'h0, 4'h7, 8'h05, 1'b0, 1'b0, 4'h0, 1'b0, 1'b1);
            rd(12'h18c, 32'h5, `PRF_RESP_OKAY);
            wr(12'h18c, 32'h0, `PRF_RESP_OKAY);
            rd(12'h18c, 32'h0, `PRF_RESP_OKAY);
            wr(12'h168, 32'h0, `PRF_RESP_OKAY);
            wr(12'h104, 32'h00020000, `PRF_RESP_OKAY);
        end
    endtask

    task t_capture;
        integer i;
        begin
            // fifth capture finds the store full and is lost
            for (i = 0; i < 5; i = i + 1)
                send(i[3:0], 4'h2, 8'h00, 1'b0, 1'b1, i[3:0], 1'b0, i < 4);
            chk("rx_capture_count", 32'h4, rx_capture_count);
            rd(12'h108, 32'h4, `PRF_RESP_OKAY);
            for (i = 0; i < 4; i = i + 1) begin
                rd(12'h16c, 32'h50000000 + i, `PRF_RESP_OKAY);
                rd(12'h170, {2'b00, 30'h3fffff00 + i[29:0]}, `PRF_RESP_OKAY);
                rd(12'h174, {12'ha00 + i[11:0], i[3:0], 16'h1000 + i[15:0]},
                   `PRF_RESP_OKAY);
                capture_pop <= 1'b1;
                @(posedge aclk);
                capture_pop <= 1'b0;
                @(posedge aclk);
            end
            #1;
            chk("rx_capture_count", 32'h0, rx_capture_count);
            @(posedge aclk);
        end
    endtask

    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_reset_bank;
        t_type_masks;
        t_field_filters;
        t_capture;
        tally_and_finish;
    end
endmodule
